// File: common/acs_regs.svh
// register offsets, field positions, reset values and timing counts of the
// conversion sequencer; definitions only, included by bare name
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ****************************************************************
// register byte offsets (apb, one aligned word each)
// ****************************************************************
`define ACS_OFF_CTRL_A 8'h00
`define ACS_OFF_CTRL_B 8'h04
`define ACS_OFF_RESULT 8'h08
`define ACS_OFF_IRQ_STATUS 8'h0c
`define ACS_OFF_IRQ_MASK 8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define ACS_A_START 7
`define ACS_A_IN_PROGRESS 6
`define ACS_A_POWER_OFF 5
`define ACS_B_REF_SEL 4
`define ACS_B_DIV_HI 2
`define ACS_B_DIV_LO 0
`define ACS_IRQ_DONE 0

// ****************************************************************
// reset values
// ****************************************************************
`define ACS_RST_START 1'b0
`define ACS_RST_IN_PROGRESS 1'b1
`define ACS_RST_POWER_OFF 1'b1
`define ACS_RST_REF_SEL 1'b0
`define ACS_RST_DIV 3'h0
`define ACS_RST_MASK 1'b0

// ****************************************************************
// timing: conversion length in conversion clock periods, and the divider code that stops the clock
// ****************************************************************
`define ACS_CONV_PERIODS 5'h10
`define ACS_DIV_UNDEFINED 3'h7

`endif

// File: common/acs_pkg.sv
// types shared by the conversion sequencer and its prescaler
// assumes the constants of acs_regs.svh for offsets and counts
package acs_pkg;

	// gray along idle -> hold -> convert; convert -> idle flips both bits
	typedef enum logic [1:0] {
		ACS_IDLE = 2'h0,
		ACS_HOLD = 2'h1,
		ACS_CONVERT = 2'h3
	} acs_state_t;

	typedef logic [2:0] acs_div_sel_t;

endpackage

// File: rtl/acs_clk_div.sv
// conversion clock prescaler: one tick per conversion clock period
// assumes pclk is the system clock; restart realigns the period
`timescale 1ns/1ns
`include "acs_regs.svh"

module acs_clk_div (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic restart,
	input wire acs_pkg::acs_div_sel_t div_sel,
	// conversion clock tick
	output logic tick
);

	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic [5:0] limit;
	logic tick_ff;
	logic nxt_tick;

	// ****************************************************************
	// divide by 1,2,4 .. 64; undefined code stops the clock
	// ****************************************************************
	always_comb begin
		case (div_sel)
			3'h0: limit = 6'h00;
			3'h1: limit = 6'h01;
			3'h2: limit = 6'h03;
			3'h3: limit = 6'h07;
			3'h4: limit = 6'h0f;
			3'h5: limit = 6'h1f;
			3'h6: limit = 6'h3f;
			default: limit = 6'h00;
		endcase
		nxt_cnt = cnt_ff + 6'h01;
		nxt_tick = 1'b0;
		if (restart || div_sel == `ACS_DIV_UNDEFINED) begin
			nxt_cnt = 6'h00;
		end else if (cnt_ff >= limit) begin
			nxt_cnt = 6'h00;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

endmodule

// File: rtl/acs_sequencer.sv
// conversion sequencer: apb registers, start/reset control, in-progress
// flag, completion interrupt, prescaler, power and reference control
// assumes the analog converter steps on conv_step and presents its result
// on conv_result, same clock as pclk
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "acs_regs.svh"

module acs_sequencer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog converter
	input wire logic [11:0] conv_result,
	output logic conv_reset,
	output logic conv_power_down,
	output logic conv_step,
	output logic conv_ref_external,
	// shared reference pin
	output logic ref_pin_ref_fn,
	output logic ref_pin_other_fn_disable,
	// interrupt
	output logic irq
);

	// ****************************************************************
	// state
	// ****************************************************************
	acs_pkg::acs_state_t state_ff;
	acs_pkg::acs_state_t nxt_state;
	logic start_ff;
	logic nxt_start;
	logic in_progress_ff;
	logic nxt_in_progress;
	logic power_off_ff;
	logic nxt_power_off;
	logic ref_sel_ff;
	logic nxt_ref_sel;
	acs_pkg::acs_div_sel_t div_sel_ff;
	acs_pkg::acs_div_sel_t nxt_div_sel;
	logic [4:0] period_cnt_ff;
	logic [4:0] nxt_period_cnt;
	logic [11:0] result_ff;
	logic [11:0] nxt_result;
	logic irq_status_ff;
	logic nxt_irq_status;
	logic irq_mask_ff;
	logic nxt_irq_mask;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic irq_ff;
	logic nxt_irq;

	logic setup;
	logic access;
	logic wr;
	logic mapped;
	logic div_restart;
	logic tick;
	logic step;
	logic done;

	// ****************************************************************
	// apb decode
	// ****************************************************************
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;

	always_comb begin
		case (paddr)
			`ACS_OFF_CTRL_A,
			`ACS_OFF_CTRL_B,
			`ACS_OFF_RESULT,
			`ACS_OFF_IRQ_STATUS,
			`ACS_OFF_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// ****************************************************************
	// conversion clock prescaler
	// ****************************************************************
	// the undefined code parks the prescaler, so a conversion stalls
	acs_clk_div u_clk_div (
		.pclk(pclk),
		.presetn(presetn),
		.restart(div_restart),
		.div_sel(div_sel_ff),
		.tick(tick)
	);

	// a powered-down converter makes no progress; a start write landing
	// mid-conversion holds the converter in reset, so no step that cycle
	assign step = tick && (state_ff == acs_pkg::ACS_CONVERT)
		&& !power_off_ff && !start_ff;
	assign done = step && (period_cnt_ff == `ACS_CONV_PERIODS - 5'h01);

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_comb begin
		nxt_start = start_ff;
		nxt_power_off = power_off_ff;
		nxt_ref_sel = ref_sel_ff;
		nxt_div_sel = div_sel_ff;
		nxt_irq_mask = irq_mask_ff;
		if (wr && paddr == `ACS_OFF_CTRL_A) begin
			// in-progress bit is status only; writes to it fall away
			nxt_start = pwdata[`ACS_A_START];
			nxt_power_off = pwdata[`ACS_A_POWER_OFF];
		end
		if (wr && paddr == `ACS_OFF_CTRL_B) begin
			nxt_ref_sel = pwdata[`ACS_B_REF_SEL];
			nxt_div_sel = pwdata[`ACS_B_DIV_HI:`ACS_B_DIV_LO];
		end
		if (wr && paddr == `ACS_OFF_IRQ_MASK) begin
			nxt_irq_mask = pwdata[`ACS_IRQ_DONE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_ff <= `ACS_RST_START;
			power_off_ff <= `ACS_RST_POWER_OFF;
			ref_sel_ff <= `ACS_RST_REF_SEL;
			div_sel_ff <= `ACS_RST_DIV;
			irq_mask_ff <= `ACS_RST_MASK;
		end else begin
			start_ff <= nxt_start;
			power_off_ff <= nxt_power_off;
			ref_sel_ff <= nxt_ref_sel;
			div_sel_ff <= nxt_div_sel;
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// ****************************************************************
	// conversion sequence
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_in_progress = in_progress_ff;
		nxt_period_cnt = period_cnt_ff;
		nxt_result = result_ff;
		div_restart = 1'b0;
		case (state_ff)
			acs_pkg::ACS_IDLE: begin
				if (start_ff) begin
					nxt_state = acs_pkg::ACS_HOLD;
				end
			end
			acs_pkg::ACS_HOLD: begin
				nxt_in_progress = 1'b1;
				nxt_period_cnt = 5'h00;
				div_restart = 1'b1;
				if (!start_ff) begin
					// falling start edge launches the conversion
					nxt_state = acs_pkg::ACS_CONVERT;
				end
			end
			acs_pkg::ACS_CONVERT: begin
				if (start_ff) begin
					// raising start again aborts and re-resets
					nxt_state = acs_pkg::ACS_HOLD;
				end else if (done) begin
					nxt_state = acs_pkg::ACS_IDLE;
					nxt_in_progress = 1'b0;
					nxt_result = conv_result;
					nxt_period_cnt = 5'h00;
				end else if (step) begin
					// power-off stalls the count rather than aborting it
					nxt_period_cnt = period_cnt_ff + 5'h01;
				end
			end
			default: begin
				nxt_state = acs_pkg::ACS_IDLE;
			end
		endcase
		if (start_ff) begin
			nxt_in_progress = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= acs_pkg::ACS_IDLE;
			in_progress_ff <= `ACS_RST_IN_PROGRESS;
			period_cnt_ff <= 5'h00;
			result_ff <= 12'h000;
		end else begin
			state_ff <= nxt_state;
			in_progress_ff <= nxt_in_progress;
			period_cnt_ff <= nxt_period_cnt;
			result_ff <= nxt_result;
		end
	end

	// ****************************************************************
	// interrupt: sticky done flag, cleared by reading status
	// ****************************************************************
	always_comb begin
		nxt_irq_status = irq_status_ff;
		// clear only what the reader saw; a new completion still sets
		if (access && !pwrite && paddr == `ACS_OFF_IRQ_STATUS && prdata_ff[`ACS_IRQ_DONE]) begin
			nxt_irq_status = 1'b0;
		end
		if (done) begin
			nxt_irq_status = 1'b1;
		end
		// built from next values so irq rises with the status bit
		nxt_irq = nxt_irq_status && nxt_irq_mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			irq_status_ff <= nxt_irq_status;
			irq_ff <= nxt_irq;
		end
	end

	assign irq = irq_ff;

	// ****************************************************************
	// read data, captured in the setup cycle
	// ****************************************************************
	always_comb begin
		nxt_prdata = prdata_ff;
		if (setup) begin
			nxt_prdata = 32'h0000_0000;
			case (paddr)
				`ACS_OFF_CTRL_A: begin
					nxt_prdata[`ACS_A_START] = start_ff;
					nxt_prdata[`ACS_A_IN_PROGRESS] = in_progress_ff;
					nxt_prdata[`ACS_A_POWER_OFF] = power_off_ff;
				end
				`ACS_OFF_CTRL_B: begin
					nxt_prdata[`ACS_B_REF_SEL] = ref_sel_ff;
					nxt_prdata[`ACS_B_DIV_HI:`ACS_B_DIV_LO] = div_sel_ff;
				end
				`ACS_OFF_RESULT: nxt_prdata[11:0] = result_ff;
				`ACS_OFF_IRQ_STATUS: nxt_prdata[`ACS_IRQ_DONE] = irq_status_ff;
				`ACS_OFF_IRQ_MASK: nxt_prdata[`ACS_IRQ_DONE] = irq_mask_ff;
				// unmapped offsets read zero and raise pslverr
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	assign prdata = prdata_ff;

	// ****************************************************************
	// converter and pin control
	// ****************************************************************
	assign conv_reset = (state_ff == acs_pkg::ACS_HOLD) || start_ff;
	assign conv_power_down = power_off_ff;
	assign conv_step = step;
	assign conv_ref_external = ref_sel_ff;
	assign ref_pin_ref_fn = ref_sel_ff;
	assign ref_pin_other_fn_disable = ref_sel_ff;

endmodule

// File: testbench/acs_sequencer_assertions.sv
// checker on the ports of the conversion sequencer
// assumes one pclk domain and presetn async active low
`timescale 1ns/1ns
`include "acs_regs.svh"
module acs_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// converter, pin and interrupt
	input wire logic conv_reset,
	input wire logic conv_power_down,
	input wire logic conv_step,
	input wire logic conv_ref_external,
	input wire logic ref_pin_ref_fn,
	input wire logic ref_pin_other_fn_disable,
	input wire logic irq
);
	logic wr;
	logic mask_wr;
	logic [2:0] div_ff;
	logic [2:0] nxt_div;
	logic [4:0] steps_ff;
	logic [4:0] nxt_steps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = psel && penable && pwrite;
	assign mask_wr = wr && paddr == `ACS_OFF_IRQ_MASK;
	// shadow of the divider code, so spacing can be judged from the ports
	always_comb begin
		nxt_div = (wr && paddr == `ACS_OFF_CTRL_B) ? pwdata[2:0] : div_ff;
		nxt_steps = conv_reset ? 5'h00 : steps_ff + {4'h0, conv_step};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 3'h0;
			steps_ff <= 5'h00;
		end else begin
			div_ff <= nxt_div;
			steps_ff <= nxt_steps;
		end
	end
	a_start_resets: assert property (
		wr && paddr == `ACS_OFF_CTRL_A && pwdata[7] |=> conv_reset) else $error("no reset");
	a_no_step_reset: assert property (
		conv_step |-> !conv_reset && !conv_power_down) else $error("step in reset");
	a_power_bit: assert property (
		wr && paddr == `ACS_OFF_CTRL_A |=> conv_power_down == $past(pwdata[5]))
		else $error("power bit");
	a_ref_bit: assert property (
		wr && paddr == `ACS_OFF_CTRL_B |=> conv_ref_external == $past(pwdata[4]))
		else $error("ref bit");
	a_ref_pin: assert property (
		ref_pin_ref_fn == conv_ref_external && ref_pin_other_fn_disable == conv_ref_external)
		else $error("pin override");
	a_step_gap: assert property (
		conv_step && div_ff != 3'h0 |=> !conv_step) else $error("step spacing");
	a_undef_quiet: assert property (
		div_ff == 3'h7 && $past(div_ff) == 3'h7 |-> !conv_step) else $error("undef step");
	a_step_count: assert property (
		steps_ff <= 5'h10) else $error("too many steps");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(conv_step || mask_wr) || $past(conv_step || mask_wr, 2))
		else $error("irq cause");
	cover property (conv_step && div_ff == 3'h6);
	cover property ($rose(irq));
	cover property (div_ff == 3'h7 && !conv_reset);
endmodule
bind acs_sequencer acs_checker u_acs_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.conv_reset(conv_reset), .conv_power_down(conv_power_down), .conv_step(conv_step),
	.conv_ref_external(conv_ref_external), .ref_pin_ref_fn(ref_pin_ref_fn),
	.ref_pin_other_fn_disable(ref_pin_other_fn_disable), .irq(irq));

// File: testbench/acs_sequencer_bench.sv
// self-checking bench for the conversion sequencer over apb
// assumes a zero-wait slave and the offsets of acs_regs.svh
`timescale 1ns/1ns
`include "acs_regs.svh"
module acs_sequencer_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, conv_reset, conv_power_down, conv_step, cref, rfn, rdis, irq;
	logic [11:0] conv_result = 12'h000;
	int mismatches = 0, tests_run = 0, steps = 0, cyc = 0, n;
	// settling time after power-on is not fixed; a plain choice
	localparam int settle_cycles = 8;
	always #20 pclk = ~pclk;
	acs_sequencer u_acs_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_result(conv_result),
		.conv_reset(conv_reset), .conv_power_down(conv_power_down), .conv_step(conv_step),
		.conv_ref_external(cref), .ref_pin_ref_fn(rfn), .ref_pin_other_fn_disable(rdis),
		.irq(irq));
	// ********
	// bus and compare tasks
	// ********
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic start(input logic [2:0] code, input logic [31:0] mask);
		apb(1'b1, `ACS_OFF_IRQ_MASK, mask);
		apb(1'b1, `ACS_OFF_CTRL_B, {29'h0, code});
		apb(1'b1, `ACS_OFF_CTRL_A, 32'h80);
		@(negedge pclk);
		chk("conv_reset", 32'h1, {31'h0, conv_reset});
		rdchk("flag in reset", `ACS_OFF_CTRL_A, 32'hc0);
		steps = 0;
		apb(1'b1, `ACS_OFF_CTRL_A, 32'h00);
		n = 0;
	endtask
	// hang guard: the longest conversion is about a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (conv_step === 1'b1) steps++;
		if (cyc == 30000) begin
			chk("timeout", 32'h0, 32'h1);
			complete_run;
		end
	end
	// ********
	// scenarios
	// ********
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("ctrl_a reset", `ACS_OFF_CTRL_A, 32'h60);
		apb(1'b1, `ACS_OFF_CTRL_A, 32'h00);
		rdchk("flag read-only", `ACS_OFF_CTRL_A, 32'h40);
		chk("power down", 32'h0, {31'h0, conv_power_down});
		repeat (settle_cycles) @(posedge pclk);
		apb(1'b1, `ACS_OFF_CTRL_B, 32'h10);
		@(negedge pclk);
		chk("ref pin", 32'h7, {29'h0, cref, rfn, rdis});
		rdchk("unmapped", 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		for (int c = 0; c < 7; c++) begin
			conv_result <= 12'h5a0 + 12'(c);
			start(3'(c), 32'h1);
			while (steps < 16 && n < 1100) begin
				@(negedge pclk);
				n++;
			end
			chk("period", 32'h1, {31'h0, n >= (16 << c) && n <= (16 << c) + 4});
			repeat (3) @(negedge pclk);
			chk("steps", 32'h10, 32'(steps));
			chk("irq", 32'h1, {31'h0, irq});
			rdchk("flag clear", `ACS_OFF_CTRL_A, 32'h0);
			rdchk("result", `ACS_OFF_RESULT, {20'h0, conv_result});
			rdchk("status", `ACS_OFF_IRQ_STATUS, 32'h1);
			rdchk("status cleared", `ACS_OFF_IRQ_STATUS, 32'h0);
			chk("irq low", 32'h0, {31'h0, irq});
		end
		start(3'h4, 32'h0);
		do begin
			apb(1'b0, `ACS_OFF_CTRL_A, 32'h0);
			n++;
		end while (rd[6] !== 1'b0 && n < 400);
		chk("poll done", 32'h0, {31'h0, rd[6]});
		chk("masked irq", 32'h0, {31'h0, irq});
		rdchk("masked status", `ACS_OFF_IRQ_STATUS, 32'h1);
		start(3'h7, 32'h1);
		repeat (300) @(negedge pclk);
		chk("undef steps", 32'h0, 32'(steps));
		rdchk("undef flag", `ACS_OFF_CTRL_A, 32'h40);
		rdchk("undef status", `ACS_OFF_IRQ_STATUS, 32'h0);
		apb(1'b1, `ACS_OFF_CTRL_A, 32'h20);
		@(negedge pclk);
		chk("powered off", 32'h1, {31'h0, conv_power_down});
		chk("ref pin off", 32'h0, {29'h0, cref, rfn, rdis});
		complete_run;
	end
endmodule
